//--- verilog/ssa_annunciator.sv
// Purpose: status lines and panel indicators of the supply
// Assumes: condition inputs are synchronous to clk_i
// Notes:   all status lines and lamps come from flip-flops
`include "ssa_cfg.svh"

// Function
// - output-active line low while contactor closed and output on.
// - setpoint-reached line low while output on and equal to setpoint.
// - arc line low when overcurrent trip point is reached.
// - life-expired line low when selected target counter has run out.
// - two target-select lines jointly encode the selected target.
// - arc lights arc lamp, fires arc shutdown, sounds alarm.
// - ramp lamp steady while ramping, off once setpoint reached.
// - ramp lamp flashes while a ramp is paused.
// - setpoint lamp steady at setpoint, off when output off.
// - output on but off setpoint sounds alarm and, with plasma, flashes setpoint lamp.
// - setpoint lamp dark whenever plasma lamp is dark.
// - plasma lamp only when output on and current above 1/1024 max.
// - output lamp lit whenever output is turned on.
// - ten lamps on standard panel, nine on reduced panel.
module ssa_annunciator import ssa_pkg::*; #(
	parameter logic [31:0] FLASH_HALF_CYC = `SSA_FLASH_HALF_CYC
) (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic [`SSA_ADDR_W-1:0]    addr_i,
	input  wire logic [`SSA_DATA_W-1:0]    wdata_i,
	input  wire logic                      wr_i,
	input  wire logic                      rd_i,
	output logic [`SSA_DATA_W-1:0]         rdata_o,
	input  wire logic                      output_on_i,
	input  wire logic                      contactor_closed_i,
	input  wire logic                      setpoint_match_i,
	input  wire logic                      ramping_i,
	input  wire logic                      ramp_paused_i,
	input  wire logic                      overcurrent_trip_i,
	input  wire logic [`SSA_CUR_W-1:0]     output_current_i,
	input  wire logic [1:0]                target_sel_i,
	input  wire logic [`SSA_TARGET_N-1:0]  life_zero_i,
	input  wire logic [`SSA_FAULT_N-1:0]   fault_led_req_i,
	output logic                           output_active_n_o,
	output logic                           setpoint_reached_n_o,
	output logic                           arc_n_o,
	output logic                           life_expired_n_o,
	output logic                           target_select_line_a_o,
	output logic                           target_select_line_b_o,
	output logic [`SSA_LED_N-1:0]          led_o,
	output logic                           arc_shutdown_o,
	output logic                           alarm_o
);

	// counter selected by a target code; code zero selects nothing
	function automatic logic sel_life(input logic [1:0] sel,
		input logic [`SSA_TARGET_N-1:0] zero);
		logic r;
		r = 1'h0;
		if (sel != `SSA_SEL_NONE) begin
			r = zero[sel - 2'h1];
		end
		return r;
	endfunction

	function automatic logic hit(input logic [`SSA_ADDR_W-1:0] a,
		input logic [`SSA_ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction

	ssa_ind_if ind ();

	ssa_flash_gen #(
		.HALF_CYC (FLASH_HALF_CYC)
	) u_flash (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ind   (ind.flash)
	);

	ssa_plasma_cmp u_cmp (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ind   (ind.cmp)
	);

	ssa_panel_t                panel_ff;
	logic [`SSA_CUR_W-1:0]     maxcur_ff;
	logic                      arc_latch_ff;
	logic                      trip_prev_ff;
	logic [`SSA_ARCCNT_W-1:0]  arccnt_ff;
	ssa_ramp_st_t              ramp_st_ff;
	ssa_ramp_st_t              nxt_ramp_st;
	logic                      plasma;
	logic                      on_active;
	logic                      arc_set;
	logic                      arc_clr;
	logic                      arc_edge;
	logic                      life_end;
	logic                      sp_flash;
	logic [`SSA_LED_N-1:0]     nxt_led;
	logic [`SSA_DATA_W-1:0]    nxt_rdata;
	logic [`SSA_LED_N-1:0]     led_ff;
	logic                      output_active_n_ff;
	logic                      setpoint_reached_n_ff;
	logic                      arc_n_ff;
	logic                      life_expired_n_ff;
	logic                      line_a_ff;
	logic                      line_b_ff;
	logic                      shutdown_ff;
	logic                      alarm_ff;
	logic [`SSA_DATA_W-1:0]    rdata_ff;

	assign ind.current     = output_current_i;
	assign ind.max_current = maxcur_ff;

	// register writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			panel_ff <= SSA_PANEL_STANDARD;
		end else if (wr_i && hit(addr_i, `SSA_OFS_CTRL)) begin
			panel_ff <= ssa_panel_t'(wdata_i[`SSA_CTRL_REDUCED]);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			maxcur_ff <= `SSA_MAXCUR_RST;
		end else if (wr_i && hit(addr_i, `SSA_OFS_MAXCUR)) begin
			maxcur_ff <= wdata_i[`SSA_CUR_W-1:0];
		end
	end

	// clearing needs bit1, so panel mode writes leave the arc latch alone
	assign arc_clr = wr_i && hit(addr_i, `SSA_OFS_CTRL) && wdata_i[`SSA_CTRL_ARC_CLR];
	assign arc_set = overcurrent_trip_i;

	// arc latch
	// a trip in the clearing cycle still latches, so no arc is lost
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			arc_latch_ff <= 1'h0;
		end else if (arc_set) begin
			arc_latch_ff <= 1'h1;
		end else if (arc_clr) begin
			arc_latch_ff <= 1'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trip_prev_ff <= 1'h0;
		end else begin
			trip_prev_ff <= overcurrent_trip_i;
		end
	end

	// rising edges only, so one long arc counts once
	assign arc_edge = overcurrent_trip_i && !trip_prev_ff;

	// saturating, so a noisy arc storm never wraps to a small count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			arccnt_ff <= '0;
		end else if (arc_edge && arccnt_ff != `SSA_ARCCNT_MAX) begin
			arccnt_ff <= arccnt_ff + 16'h1;
		end
	end

	always_comb begin
		nxt_ramp_st = ramp_st_ff;
		case (ramp_st_ff)
			SSA_RAMP_IDLE: begin
				if (output_on_i && ramping_i && !setpoint_match_i) begin
					nxt_ramp_st = SSA_RAMP_ACTIVE;
				end
			end
			SSA_RAMP_ACTIVE: begin
				if (!output_on_i || setpoint_match_i) begin
					nxt_ramp_st = SSA_RAMP_IDLE;
				end else if (ramp_paused_i) begin
					nxt_ramp_st = SSA_RAMP_PAUSED;
				end
			end
			SSA_RAMP_PAUSED: begin
				if (!output_on_i || setpoint_match_i) begin
					nxt_ramp_st = SSA_RAMP_IDLE;
				end else if (!ramp_paused_i) begin
					nxt_ramp_st = SSA_RAMP_ACTIVE;
				end
			end
			default: begin
				nxt_ramp_st = SSA_RAMP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ramp_st_ff <= SSA_RAMP_IDLE;
		end else begin
			ramp_st_ff <= nxt_ramp_st;
		end
	end

	assign plasma    = output_on_i && ind.plasma_above;
	assign on_active = output_on_i && contactor_closed_i;
	assign life_end  = sel_life(target_sel_i, life_zero_i);
	assign sp_flash  = output_on_i && !setpoint_match_i;

	always_comb begin
		nxt_led = '0;
		nxt_led[`SSA_LED_ARC] = arc_latch_ff;
		case (ramp_st_ff)
			SSA_RAMP_ACTIVE: nxt_led[`SSA_LED_RAMP] = 1'h1;
			SSA_RAMP_PAUSED: nxt_led[`SSA_LED_RAMP] = ind.blink;
			default:         nxt_led[`SSA_LED_RAMP] = 1'h0;
		endcase
		if (plasma) begin
			if (setpoint_match_i) begin
				nxt_led[`SSA_LED_SETPOINT] = 1'h1;
			end else if (sp_flash) begin
				nxt_led[`SSA_LED_SETPOINT] = ind.blink;
			end
		end
		nxt_led[`SSA_LED_PLASMA] = plasma;
		nxt_led[`SSA_LED_OUTPUT] = output_on_i;
		// fault lamps pass straight through, the extra one only on the standard panel; their flashing belongs to the fault logic
		nxt_led[`SSA_LED_LIFE]   = fault_led_req_i[`SSA_FAULT_LIFE];
		nxt_led[`SSA_LED_TEMP]   = fault_led_req_i[`SSA_FAULT_TEMP];
		nxt_led[`SSA_LED_WATER]  = fault_led_req_i[`SSA_FAULT_WATER];
		nxt_led[`SSA_LED_VACUUM] = fault_led_req_i[`SSA_FAULT_VACUUM];
		nxt_led[`SSA_LED_EXTRA]  = fault_led_req_i[`SSA_FAULT_EXTRA]
			&& (panel_ff == SSA_PANEL_STANDARD);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			led_ff <= '0;
		end else begin
			led_ff <= nxt_led;
		end
	end

	// status lines idle high, true low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			output_active_n_ff    <= 1'h1;
			setpoint_reached_n_ff <= 1'h1;
			arc_n_ff              <= 1'h1;
			life_expired_n_ff     <= 1'h1;
		end else begin
			output_active_n_ff    <= !on_active;
			setpoint_reached_n_ff <= !(output_on_i && setpoint_match_i);
			arc_n_ff              <= !arc_latch_ff;
			life_expired_n_ff     <= !life_end;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_a_ff <= 1'h1;
			line_b_ff <= 1'h1;
		end else begin
			line_a_ff <= !target_sel_i[0];
			line_b_ff <= !target_sel_i[1];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shutdown_ff <= 1'h0;
			alarm_ff    <= 1'h0;
		end else begin
			shutdown_ff <= arc_latch_ff;
			alarm_ff    <= arc_latch_ff || sp_flash;
		end
	end

	// register reads; unmapped addresses read zero
	always_comb begin
		nxt_rdata = '0;
		if (hit(addr_i, `SSA_OFS_CTRL)) begin
			nxt_rdata[`SSA_CTRL_REDUCED] = panel_ff;
			nxt_rdata[`SSA_CTRL_ARC_CLR] = arc_latch_ff;
		end else if (hit(addr_i, `SSA_OFS_MAXCUR)) begin
			nxt_rdata[`SSA_CUR_W-1:0] = maxcur_ff;
		end else if (hit(addr_i, `SSA_OFS_COND)) begin
			// live snapshot; the arc bit and the ramp state bits are held
			nxt_rdata[`SSA_COND_ON]      = output_on_i;
			nxt_rdata[`SSA_COND_CONTACT] = contactor_closed_i;
			nxt_rdata[`SSA_COND_MATCH]   = setpoint_match_i;
			nxt_rdata[`SSA_COND_ARC]     = arc_latch_ff;
			nxt_rdata[`SSA_COND_RAMPING] = (ramp_st_ff == SSA_RAMP_ACTIVE);
			nxt_rdata[`SSA_COND_PAUSED]  = (ramp_st_ff == SSA_RAMP_PAUSED);
			nxt_rdata[`SSA_COND_PLASMA]  = plasma;
			nxt_rdata[`SSA_COND_LIFE]    = life_end;
		end else if (hit(addr_i, `SSA_OFS_LEDS)) begin
			nxt_rdata[`SSA_LED_N-1:0] = led_ff;
		end else if (hit(addr_i, `SSA_OFS_ARCCNT)) begin
			nxt_rdata[`SSA_ARCCNT_W-1:0] = arccnt_ff;
		end
	end

	// read data stand for the one cycle after the strobe only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_ff <= '0;
		end else if (rd_i) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= '0;
		end
	end

	assign rdata_o                = rdata_ff;
	assign led_o                  = led_ff;
	assign output_active_n_o      = output_active_n_ff;
	assign setpoint_reached_n_o   = setpoint_reached_n_ff;
	assign arc_n_o                = arc_n_ff;
	assign life_expired_n_o       = life_expired_n_ff;
	assign target_select_line_a_o = line_a_ff;
	assign target_select_line_b_o = line_b_ff;
	assign arc_shutdown_o         = shutdown_ff;
	assign alarm_o                = alarm_ff;
endmodule

//--- shared/ssa_cfg.svh
// Purpose: constants of the supply status annunciator
// Assumes: 250 MHz control clock
// Notes:   offsets are byte addresses on the plain register port
`ifndef SSA_CFG_SVH
`define SSA_CFG_SVH

`define SSA_ADDR_W          8
`define SSA_DATA_W          32
`define SSA_CUR_W           16

`define SSA_OFS_CTRL        8'h00
`define SSA_OFS_MAXCUR      8'h04
`define SSA_OFS_COND        8'h08
`define SSA_OFS_LEDS        8'h0C
`define SSA_OFS_ARCCNT      8'h10

`define SSA_CTRL_REDUCED    0
`define SSA_CTRL_ARC_CLR    1
`define SSA_MAXCUR_RST      16'hFFFF
`define SSA_ARCCNT_MAX      16'hFFFF
`define SSA_PLASMA_SHIFT    10

`define SSA_LED_N           10
`define SSA_LED_ARC         0
`define SSA_LED_RAMP        1
`define SSA_LED_SETPOINT    2
`define SSA_LED_PLASMA      3
`define SSA_LED_OUTPUT      4
`define SSA_LED_LIFE        5
`define SSA_LED_TEMP        6
`define SSA_LED_WATER       7
`define SSA_LED_VACUUM      8
`define SSA_LED_EXTRA       9
`define SSA_FAULT_N         5

`define SSA_TARGET_N        3
`define SSA_SEL_NONE        2'h0

`define SSA_FAULT_LIFE      0
`define SSA_FAULT_TEMP      1
`define SSA_FAULT_WATER     2
`define SSA_FAULT_VACUUM    3
`define SSA_FAULT_EXTRA     4

`define SSA_COND_ON         0
`define SSA_COND_CONTACT    1
`define SSA_COND_MATCH      2
`define SSA_COND_ARC        3
`define SSA_COND_RAMPING    4
`define SSA_COND_PAUSED     5
`define SSA_COND_PLASMA     6
`define SSA_COND_LIFE       7
`define SSA_ARCCNT_W        16

`define SSA_CLK_KHZ         250000
`define SSA_FLASH_HALF_MS   250
`define SSA_FLASH_HALF_CYC  (`SSA_FLASH_HALF_MS * `SSA_CLK_KHZ)

`endif

//--- shared/ssa_pkg.sv
// Purpose: types of the supply status annunciator
// Assumes: constants come from ssa_cfg.svh
// Notes:   state codes are one-hot
package ssa_pkg;
	typedef enum logic [2:0] {
		SSA_RAMP_IDLE   = 3'h1,
		SSA_RAMP_ACTIVE = 3'h2,
		SSA_RAMP_PAUSED = 3'h4
	} ssa_ramp_st_t;

	typedef enum logic {
		SSA_PANEL_STANDARD = 1'h0,
		SSA_PANEL_REDUCED  = 1'h1
	} ssa_panel_t;

	typedef logic [15:0] ssa_cur_t;
endpackage

//--- shared/ssa_ind_if.sv
// Purpose: signals shared by the annunciator and its helpers
// Assumes: one clock domain
// Notes:   blink and plasma_above are registered by their makers
interface ssa_ind_if;
	logic               blink;
	ssa_pkg::ssa_cur_t  current;
	ssa_pkg::ssa_cur_t  max_current;
	logic               plasma_above;

	modport flash (output blink);
	modport cmp   (input current, input max_current, output plasma_above);
	modport top   (input blink, input plasma_above, output current, output max_current);
endinterface

//--- verilog/ssa_flash_gen.sv
// Purpose: shared flash toggle for the ramp and setpoint lamps
// Assumes: HALF_CYC is at least two
// Notes:   one toggle keeps the ramp and setpoint lamps in phase
`include "ssa_cfg.svh"
module ssa_flash_gen import ssa_pkg::*; #(
	parameter logic [31:0] HALF_CYC = `SSA_FLASH_HALF_CYC
) (
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	ssa_ind_if.flash   ind
);
	logic [31:0] cnt_ff;
	logic        blink_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i || cnt_ff == HALF_CYC - 32'h1) begin
			cnt_ff <= 32'h0;
		end else begin
			cnt_ff <= cnt_ff + 32'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blink_ff <= 1'h0;
		end else if (cnt_ff == HALF_CYC - 32'h1) begin
			blink_ff <= ~blink_ff;
		end
	end

	assign ind.blink = blink_ff;
endmodule

//--- verilog/ssa_plasma_cmp.sv
// Purpose: plasma current threshold compare
// Assumes: max_current is the model's full-scale current
// Notes:   result lags the inputs by one clock
`include "ssa_cfg.svh"
module ssa_plasma_cmp import ssa_pkg::*; (
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	ssa_ind_if.cmp     ind
);
	logic above_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			above_ff <= 1'h0;
		end else begin
			above_ff <= ind.current > (ind.max_current >> `SSA_PLASMA_SHIFT);
		end
	end

	assign ind.plasma_above = above_ff;
endmodule

//--- sim/ssa_remote_model.sv
// Purpose: remote controller view of the annunciator status lines
// Assumes: select lines are active low
// Notes:   listens only; the controller never drives the block
module ssa_remote_model (
	input  wire logic        line_a_i,
	input  wire logic        line_b_i,
	output logic [1:0]       target_o
);
	timeunit 1ns;
	timeprecision 1ps;
	assign target_o = {~line_b_i, ~line_a_i};
endmodule

//--- sim/ssa_annunciator_properties.sv
// Purpose: port-level checks of the supply status annunciator
// Assumes: one clock, synchronous reset
// Notes:   settle counter masks edges whose history reaches into reset
`include "ssa_cfg.svh"
module ssa_annunciator_props #(
	parameter logic [31:0] FLASH_HALF_CYC = `SSA_FLASH_HALF_CYC
) (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic [`SSA_ADDR_W-1:0]    addr_i,
	input  wire logic [`SSA_DATA_W-1:0]    wdata_i,
	input  wire logic                      wr_i,
	input  wire logic                      output_on_i,
	input  wire logic                      contactor_closed_i,
	input  wire logic                      setpoint_match_i,
	input  wire logic                      ramping_i,
	input  wire logic                      ramp_paused_i,
	input  wire logic                      overcurrent_trip_i,
	input  wire logic [1:0]                target_sel_i,
	input  wire logic [`SSA_TARGET_N-1:0]  life_zero_i,
	input  wire logic                      output_active_n_o,
	input  wire logic                      setpoint_reached_n_o,
	input  wire logic                      arc_n_o,
	input  wire logic                      life_expired_n_o,
	input  wire logic                      target_select_line_a_o,
	input  wire logic                      target_select_line_b_o,
	input  wire logic [`SSA_LED_N-1:0]     led_o,
	input  wire logic                      arc_shutdown_o,
	input  wire logic                      alarm_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0]  settle_ff;
	logic        reduced_ff;
	logic        life_sel;
	logic        ok;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			settle_ff <= 2'h0;
		else if (settle_ff != 2'h3)
			settle_ff <= settle_ff + 2'h1;
	end
	// panel mode mirrored from the write port
	always_ff @(posedge clk_i) begin
		if (rst_i)
			reduced_ff <= 1'b0;
		else if (wr_i && addr_i == `SSA_OFS_CTRL)
			reduced_ff <= wdata_i[0];
	end
	assign life_sel = (target_sel_i != 2'h0) && life_zero_i[target_sel_i - 2'h1];
	assign ok = settle_ff == 2'h3;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_OUT_ACTIVE: assert property (ok |->
		output_active_n_o == !($past(contactor_closed_i) && $past(output_on_i)))
		else $error("output active line wrong");
	AST_SETPOINT_LINE: assert property (ok && $past(output_on_i) |->
		setpoint_reached_n_o == !$past(setpoint_match_i))
		else $error("setpoint line wrong");
	AST_ARC_LINE: assert property (ok && overcurrent_trip_i |-> ##2 !arc_n_o)
		else $error("arc line not low");
	AST_ARC_ACTION: assert property (ok && overcurrent_trip_i |->
		##2 (arc_shutdown_o && led_o[0] && alarm_o))
		else $error("arc lamp shutdown or alarm missing");
	AST_LIFE_LINE: assert property (ok |-> life_expired_n_o == !$past(life_sel))
		else $error("life line wrong");
	AST_TARGET_CODE: assert property (ok |->
		{target_select_line_b_o, target_select_line_a_o} == ~$past(target_sel_i))
		else $error("target code wrong");
	AST_RAMP_STEADY: assert property (ok && $past(output_on_i, 2) && $past(ramping_i, 2)
		&& !$past(setpoint_match_i, 2) && !$past(ramp_paused_i, 2) |-> led_o[1])
		else $error("ramp lamp not lit");
	AST_RAMP_OFF: assert property (ok && $past(setpoint_match_i, 2) |-> !led_o[1])
		else $error("ramp lamp lit at setpoint");
	AST_ALARM_OFFSET: assert property (ok && $past(output_on_i)
		&& !$past(setpoint_match_i) |-> alarm_o)
		else $error("alarm silent off setpoint");
	AST_SETPOINT_DARK: assert property (ok && !led_o[3] |-> !led_o[2])
		else $error("setpoint lamp without plasma");
	AST_PLASMA_GATE: assert property (ok && led_o[3] |-> $past(output_on_i))
		else $error("plasma lamp with output off");
	AST_OUTPUT_LAMP: assert property (ok |-> led_o[4] == $past(output_on_i))
		else $error("output lamp wrong");
	AST_EXTRA_REDUCED: assert property (ok && reduced_ff && $past(reduced_ff) |-> !led_o[9])
		else $error("extra lamp lit on reduced panel");
	COV_ARC: cover property (ok && !arc_n_o && arc_shutdown_o);
	COV_PAUSE: cover property (ok && ramp_paused_i && led_o[1]);
	COV_PLASMA: cover property (ok && led_o[3] && led_o[2]);
endmodule

bind ssa_annunciator ssa_annunciator_props #(.FLASH_HALF_CYC(FLASH_HALF_CYC)) u_props (
	.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.output_on_i(output_on_i), .contactor_closed_i(contactor_closed_i),
	.setpoint_match_i(setpoint_match_i), .ramping_i(ramping_i),
	.ramp_paused_i(ramp_paused_i), .overcurrent_trip_i(overcurrent_trip_i),
	.target_sel_i(target_sel_i), .life_zero_i(life_zero_i),
	.output_active_n_o(output_active_n_o), .setpoint_reached_n_o(setpoint_reached_n_o),
	.arc_n_o(arc_n_o), .life_expired_n_o(life_expired_n_o),
	.target_select_line_a_o(target_select_line_a_o),
	.target_select_line_b_o(target_select_line_b_o), .led_o(led_o),
	.arc_shutdown_o(arc_shutdown_o), .alarm_o(alarm_o)
);

//--- sim/tb_top.sv
// Purpose: directed test of the supply status annunciator
// Assumes: flash half period cut to 4 cycles
// Notes:   checks sample 1 ns after an edge so registered outputs settled
`include "ssa_cfg.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF = 4;
	logic                    clk_i, rst_i, wr_i, rd_i;
	logic [`SSA_ADDR_W-1:0]  addr_i;
	logic [`SSA_DATA_W-1:0]  wdata_i, rdata_o, rv;
	logic                    on_i, cc_i, match_i, ramp_i, pause_i, trip_i;
	logic [`SSA_CUR_W-1:0]   cur_i;
	logic [1:0]              sel_i, tgt;
	logic [2:0]              life_i;
	logic [4:0]              fault_i;
	logic                    act_n, spr_n, arc_n, life_n, lna, lnb, shut, alarm;
	logic [9:0]              led;
	int                      fail_count, n_compared, cyc, hi, diff;

	ssa_annunciator #(.FLASH_HALF_CYC(32'(HALF))) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .output_on_i(on_i),
		.contactor_closed_i(cc_i), .setpoint_match_i(match_i), .ramping_i(ramp_i),
		.ramp_paused_i(pause_i), .overcurrent_trip_i(trip_i), .output_current_i(cur_i),
		.target_sel_i(sel_i), .life_zero_i(life_i), .fault_led_req_i(fault_i),
		.output_active_n_o(act_n), .setpoint_reached_n_o(spr_n), .arc_n_o(arc_n),
		.life_expired_n_o(life_n), .target_select_line_a_o(lna),
		.target_select_line_b_o(lnb), .led_o(led), .arc_shutdown_o(shut), .alarm_o(alarm)
	);
	ssa_remote_model u_remote (.line_a_i(lna), .line_b_i(lnb), .target_o(tgt));

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// hang guard: the whole sequence needs well under 1000 cycles
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count = fail_count + 1;
			final_report();
		end
	end

	task automatic final_report();
		if (fail_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask
	// bits: on, contactor, match, ramping, paused, trip
	task automatic cond(input logic [5:0] v, input logic [15:0] c);
		@(posedge clk_i);
		{on_i, cc_i, match_i, ramp_i, pause_i, trip_i} <= v;
		cur_i <= c;
		step(3);
	endtask
	// over two flash periods a blinking lamp is lit exactly half the time
	task automatic flash(input string nm, input int ix);
		hi = 0;
		diff = 0;
		repeat (4 * HALF) begin
			@(posedge clk_i);
			#1;
			hi += led[ix];
			diff += led[1] ^ led[2];
		end
		chk(nm, 2 * HALF, hi);
	endtask

	initial begin
		{rst_i, wr_i, rd_i} = 3'h4;
		{on_i, cc_i, match_i, ramp_i, pause_i, trip_i} = 6'h00;
		addr_i = '0;
		wdata_i = '0;
		cur_i = '0;
		sel_i = '0;
		life_i = '0;
		fault_i = '0;
		fail_count = 0;
		n_compared = 0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		step(1);
		chk("reset lines", 6'h3F, {act_n, spr_n, arc_n, life_n, lna, lnb});
		chk("reset lamps", 10'h000, led);
		rd(`SSA_OFS_MAXCUR, rv);
		chk("maxcur reset", 32'h0000FFFF, rv);
		rd(8'h20, rv);
		chk("unmapped", 32'h0, rv);
		wr(`SSA_OFS_MAXCUR, 32'h00000400);
		rd(`SSA_OFS_MAXCUR, rv);
		chk("maxcur", 32'h00000400, rv);
		for (int s = 0; s < 4; s++) begin
			@(posedge clk_i);
			sel_i <= 2'(s);
			life_i <= 3'h2;
			step(3);
			chk("target", s, tgt);
			chk("life line", (s == 2) ? 1'b0 : 1'b1, life_n);
		end
		cond(6'h30, 16'h0001);
		chk("plasma at limit", 1'b0, led[3]);
		chk("setpoint dark", 1'b0, led[2]);
		chk("active line", 1'b0, act_n);
		chk("output lamp", 1'b1, led[4]);
		cond(6'h30, 16'h0002);
		chk("plasma", 1'b1, led[3]);
		chk("alarm", 1'b1, alarm);
		flash("setpoint flash", 2);
		cond(6'h38, 16'h0002);
		chk("setpoint lamp", 1'b1, led[2]);
		chk("setpoint line", 1'b0, spr_n);
		chk("alarm quiet", 1'b0, alarm);
		cond(6'h18, 16'h0002);
		chk("setpoint off", 1'b0, led[2]);
		chk("plasma off", 1'b0, led[3]);
		chk("active off", 1'b1, act_n);
		cond(6'h34, 16'h0002);
		chk("ramp lamp", 1'b1, led[1]);
		cond(6'h36, 16'h0002);
		flash("ramp flash", 1);
		chk("in phase", 0, diff);
		cond(6'h3C, 16'h0002);
		chk("ramp done", 1'b0, led[1]);
		cond(6'h01, 16'h0000);
		chk("arc set", 4'h7, {arc_n, shut, led[0], alarm});
		cond(6'h00, 16'h0000);
		rd(`SSA_OFS_COND, rv);
		chk("cond", 32'h00000008, rv);
		rd(`SSA_OFS_ARCCNT, rv);
		chk("arc count", 32'h00000001, rv);
		wr(`SSA_OFS_CTRL, 32'h00000002);
		step(3);
		chk("arc clear", 1'b1, arc_n);
		@(posedge clk_i);
		fault_i <= 5'h1F;
		step(3);
		chk("standard panel", 5'h1F, led[9:5]);
		wr(`SSA_OFS_CTRL, 32'h00000001);
		step(3);
		chk("reduced panel", 5'h0F, led[9:5]);
		rd(`SSA_OFS_LEDS, rv);
		chk("lamp register", 32'h000001E0, rv);
		rd(`SSA_OFS_CTRL, rv);
		chk("ctrl readback", 32'h00000001, rv);
		step(1);
		chk("rdata idle", 32'h0, rdata_o);
		final_report();
	end
endmodule
